//--- common/bus_port_pkg.sv
// Package for the parallel word/byte host port of the converter.
// Assumes a single 50 MHz clock domain; used by the port module only, not by its capture module.
`default_nettype none
package bus_port_pkg;
   localparam int DATA_W = 12;
   localparam int CHAN_W = 3;
   localparam int LOW_W = 8;
   localparam int NIB_W = 4;
   // Field positions inside a byte-mode upper byte
   localparam int UPPER_NIB_LSB = 8;
   localparam int TAG_LSB = 4;
   // Reset values
   localparam logic [11:0] RESULT_RST = 12'h000;
   localparam logic [11:0] WRITE_RST = 12'h000;
   localparam logic [2:0] CHAN_RST = 3'h0;
   // Minimum write strobe low time, in ns, and its cycle count (rounded up)
   localparam int WR_PULSE_NS = 10;
   localparam int CLK_NS = 20;
   localparam int WR_PULSE_CYC = ((WR_PULSE_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
                                 ((WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
   typedef enum logic [1:0] {
      idle_s,
      write_s,
      read_s
   } access_t;
endpackage
`default_nettype wire

//--- common/pin_sync_if.sv
// Interface carrying the synchronised host strobes and bus samples.
// Assumes the sampling module and the port module share clk.
`default_nettype none
interface pin_sync_if;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic word_mode;
   logic pin8;
   logic [7:0] low;
   modport src (output cs_n, rd_n, wr_n, word_mode, pin8, low);
   modport dst (input cs_n, rd_n, wr_n, word_mode, pin8, low);
endinterface
`default_nettype wire

//--- rtl/adc_word_byte_bus_port.sv
// Parallel host data port of an eight-channel converter, word and byte modes.
// Assumes the host strobes are asynchronous and the core hands over result and tag.
// Functional notes
// RULE_01 - Low eight lines carry reads and writes
// RULE_02 - Word mode: shared pin is ninth line
// RULE_03 - Byte mode: shared pin selects upper byte
// RULE_04 - Byte mode, low select: bits 7..0
// RULE_05 - Byte mode, high select: bits 11..8 on low nibble
// RULE_06 - Upper-byte read drives channel tag on 6..4
// RULE_07 - Host pads upper-byte write 7..4 with zeros
// RULE_08 - Write strobe with chip select captures data
// RULE_09 - Read strobe with chip select drives result
// RULE_10 - Lines released outside selected reads
`default_nettype none
module adc_word_byte_bus_port (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Host strobes and mode
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic word_byte_sel,
   // Low data lines, three-signal form
   input wire logic [7:0] low_data_lines_in,
   output logic [7:0] low_data_lines_out,
   output logic [7:0] low_data_lines_oe,
   // Shared ninth-bit or upper-select pin
   input wire logic ninth_bit_or_upper_select_pin_in,
   output logic ninth_bit_or_upper_select_pin_out,
   output logic ninth_bit_or_upper_select_pin_oe,
   // Upper data lines 11..9, used in word mode only
   input wire logic [2:0] high_data_lines_in,
   output logic [2:0] high_data_lines_out,
   output logic [2:0] high_data_lines_oe,
   // Core side: result and its channel
   input wire logic [11:0] result,
   input wire logic [2:0] result_chan,
   // Core side: written register word
   output logic [11:0] write_data,
   output logic write_strobe,
   output logic write_upper_pad_err
);
   pin_sync_if sync ();
   logic [2:0] high_meta;
   logic [2:0] high_sync;
   logic [1:0] wr_cnt;
   logic wr_seen;
   logic [7:0] low_hold;
   // Kind of the write in progress, latched while the strobe is sampled low
   logic commit_hold;
   logic pad_hold;
   bus_port_pkg::access_t state;
   bus_port_pkg::access_t next_state;

   pin_sampler #(.WIDTH(13)) sampler (
      .clk(clk),
      .resetn(resetn),
      .raw({cs_n, rd_n, wr_n, word_byte_sel, ninth_bit_or_upper_select_pin_in, low_data_lines_in}),
      .sync(sync.src)
   );

   // Upper lines pass the same two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         high_meta <= 3'h0;
         high_sync <= 3'h0;
      end else begin
         high_meta <= high_data_lines_in;
         high_sync <= high_meta;
      end
   end

   // Decode of the access and the byte lane
   wire selected = !sync.cs_n;
   wire rd_act = selected && !sync.rd_n; // RULE_09
   wire wr_act = selected && !sync.wr_n; // RULE_08
   wire upper_sel = !sync.word_mode && sync.pin8; // RULE_03
   wire [11:0] word_in = {high_sync, sync.pin8, sync.low}; // RULE_02

   // Read data per mode
   wire [7:0] byte_low = result[7:0]; // RULE_04
   wire [7:0] byte_high = {1'b0, result_chan, result[11:8]}; // RULE_05 RULE_06
   wire [7:0] next_low_out = sync.word_mode ? result[7:0] : (upper_sel ? byte_high : byte_low); // RULE_01
   wire next_oe = rd_act; // RULE_10

   // Access tracking: a read or a write holds its state until its strobe is seen high
   always_comb begin
      next_state = state;
      case (state)
         bus_port_pkg::idle_s: begin
            if (rd_act)
               next_state = bus_port_pkg::read_s;
            else if (wr_act)
               next_state = bus_port_pkg::write_s;
            else
               next_state = bus_port_pkg::idle_s;
         end
         bus_port_pkg::read_s: begin
            if (rd_act)
               next_state = bus_port_pkg::read_s;
            else
               next_state = bus_port_pkg::idle_s;
         end
         bus_port_pkg::write_s: begin
            if (wr_act)
               next_state = bus_port_pkg::write_s;
            else
               next_state = bus_port_pkg::idle_s;
         end
         default: begin
            next_state = bus_port_pkg::idle_s;
         end
      endcase
   end

   // Access state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= bus_port_pkg::idle_s;
      end else begin
         state <= next_state;
      end
   end

   // Write strobe low time, counted in sampled cycles and saturating
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_cnt <= 2'h0;
      end else if (state == bus_port_pkg::write_s && wr_cnt != 2'h3) begin
         wr_cnt <= wr_cnt + 2'h1;
      end else if (state != bus_port_pkg::write_s) begin
         wr_cnt <= 2'h0;
      end
   end

   // Strobe held low long enough for a committed write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_seen <= 1'b0;
      end else begin
         wr_seen <= (state == bus_port_pkg::write_s) && (wr_cnt >= 2'(bus_port_pkg::WR_PULSE_CYC - 1));
      end
   end

   // Low lane: result follows the byte lane while a read is selected
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         low_data_lines_out <= 8'h00;
         low_data_lines_oe <= 8'h00;
      end else begin
         low_data_lines_out <= next_low_out; // RULE_09
         low_data_lines_oe <= {8{next_oe}}; // RULE_10
      end
   end

   // Shared pin: driven only as bit 8 of a word-mode read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ninth_bit_or_upper_select_pin_out <= 1'b0;
         ninth_bit_or_upper_select_pin_oe <= 1'b0;
      end else begin
         ninth_bit_or_upper_select_pin_out <= result[8];
         ninth_bit_or_upper_select_pin_oe <= next_oe && sync.word_mode; // RULE_02
      end
   end

   // Upper lines 11..9: word-mode reads only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         high_data_lines_out <= 3'h0;
         high_data_lines_oe <= 3'h0;
      end else begin
         high_data_lines_out <= result[11:9];
         high_data_lines_oe <= {3{next_oe && sync.word_mode}};
      end
   end

   // Write ends when the strobe is seen high after a long enough low time
   wire wr_end = (state == bus_port_pkg::write_s) && !wr_act && (wr_seen || wr_cnt != 2'h0);

   // Low byte of a byte-mode write, kept for the upper byte
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         low_hold <= 8'h00;
      end else if (wr_act && !sync.word_mode && !sync.pin8) begin
         low_hold <= sync.low; // RULE_04
      end
   end

   // Kind and padding of the write, taken while the strobe is still low so that
   // a host changing its lines soon after the strobe rises is not misread
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         commit_hold <= 1'b0;
         pad_hold <= 1'b0;
      end else if (wr_act) begin
         commit_hold <= sync.word_mode || upper_sel; // RULE_08
         pad_hold <= upper_sel && (sync.low[7:4] != 4'h0); // RULE_07
      end
   end

   // Written word: last value sampled while the strobe is low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         write_data <= bus_port_pkg::WRITE_RST;
      end else if (wr_act && sync.word_mode) begin
         write_data <= word_in; // RULE_08
      end else if (wr_act && upper_sel) begin
         write_data <= {sync.low[3:0], low_hold}; // RULE_05
      end
   end

   // One-cycle strobe as a word or upper-byte write completes; padding flag set at each write end and held
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         write_strobe <= 1'b0;
         write_upper_pad_err <= 1'b0;
      end else begin
         write_strobe <= wr_end && commit_hold; // RULE_08
         if (wr_end)
            write_upper_pad_err <= pad_hold; // RULE_07
      end
   end
endmodule
`default_nettype wire

//--- rtl/pin_sampler.sv
// Two-flop synchroniser for the host strobes, mode, shared pin and low lines feeding the port.
// Assumes the pins are asynchronous to clk.
`default_nettype none
module pin_sampler #(
   parameter int WIDTH = 13
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Raw pins: cs_n, rd_n, wr_n, word_mode, pin8, low[7:0]
   input wire logic [WIDTH-1:0] raw,
   // Synchronised view
   pin_sync_if.src sync
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stable;

   // Strobes idle high so reset leaves them inactive
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta <= 13'h1C00;
         stable <= 13'h1C00;
      end else begin
         meta <= raw;
         stable <= meta;
      end
   end

   assign sync.cs_n = stable[12];
   assign sync.rd_n = stable[11];
   assign sync.wr_n = stable[10];
   assign sync.word_mode = stable[9];
   assign sync.pin8 = stable[8];
   assign sync.low = stable[7:0];
endmodule
`default_nettype wire

//--- tb/adc_word_byte_bus_port_asserts.sv
// Checker for the word/byte host port, bound to it.
// Assumes mode, select and result stay steady during an access.
`default_nettype none
module adc_word_byte_bus_port_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Host strobes and mode
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic word_byte_sel,
   // Data lines as seen and driven by the port
   input wire logic ninth_bit_or_upper_select_pin_in,
   input wire logic ninth_bit_or_upper_select_pin_out,
   input wire logic ninth_bit_or_upper_select_pin_oe,
   input wire logic [7:0] low_data_lines_out,
   input wire logic [7:0] low_data_lines_oe,
   input wire logic [2:0] high_data_lines_out,
   input wire logic [2:0] high_data_lines_oe,
   // Core side
   input wire logic [11:0] result,
   input wire logic [2:0] result_chan,
   input wire logic write_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Short views of the watched ports
   wire rd = !cs_n && !rd_n;
   wire wbs = word_byte_sel;
   wire up = !wbs && ninth_bit_or_upper_select_pin_in;
   wire [7:0] lo = low_data_lines_out;
   wire [7:0] loe = low_data_lines_oe;
   wire [2:0] hoe = high_data_lines_oe;
   wire p8oe = ninth_bit_or_upper_select_pin_oe;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Reads are judged once held five cycles, past the sync latency
   a_read_drive: assert property (rd [*5] |-> loe == 8'hFF && p8oe == wbs && hoe == {3{wbs}})
      else $error("lines not driven");
   a_sel_input: assert property (!wbs && !$past(wbs, 3) |-> !p8oe && hoe == 3'h0)
      else $error("select pin driven");
   a_byte_low: assert property ((rd && !wbs && !up) [*5] |-> lo == result[7:0])
      else $error("wrong low byte");
   a_byte_high: assert property ((rd && up) [*5] |-> lo[3:0] == result[11:8] && !lo[7])
      else $error("wrong upper nibble");
   a_chan_tag: assert property ((rd && up) [*5] |-> lo[6:4] == result_chan)
      else $error("wrong channel tag");
   a_write_strobe: assert property ($rose(wr_n) && !cs_n && (wbs || up) |-> ##[2:5] write_strobe)
      else $error("no write strobe");
   a_word_result: assert property ((rd && wbs) [*5] |->
      {high_data_lines_out, ninth_bit_or_upper_select_pin_out, lo} == result) else $error("wrong result");
   a_bus_release: assert property (!rd [*5] |-> loe == 8'h00 && !p8oe && hoe == 3'h0)
      else $error("bus not released");
   c_word_read: cover property ((rd && wbs) [*5]);
   c_upper_read: cover property ((rd && up) [*5]);
   c_write: cover property (write_strobe);
endmodule
bind adc_word_byte_bus_port adc_word_byte_bus_port_asserts chk (
   .clk(clk), .resetn(resetn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .word_byte_sel(word_byte_sel),
   .ninth_bit_or_upper_select_pin_in(ninth_bit_or_upper_select_pin_in),
   .ninth_bit_or_upper_select_pin_out(ninth_bit_or_upper_select_pin_out),
   .ninth_bit_or_upper_select_pin_oe(ninth_bit_or_upper_select_pin_oe),
   .low_data_lines_out(low_data_lines_out), .low_data_lines_oe(low_data_lines_oe),
   .high_data_lines_out(high_data_lines_out), .high_data_lines_oe(high_data_lines_oe),
   .result(result), .result_chan(result_chan), .write_strobe(write_strobe)
);
`default_nettype wire

//--- tb/adc_word_byte_bus_port_tb.sv
// Bench for the word/byte host port with a host bus model.
// Assumes the bound checker watches the port meanwhile.
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
module adc_word_byte_bus_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, resetn = 1'b0;
   logic [11:0] result = 12'h000, q;
   logic [2:0] result_chan = 3'h0;
   int err_total = 0, compares = 0, strobes = 0;
   wire cs_n, rd_n, wr_n, word_byte_sel, sel, write_strobe, write_upper_pad_err;
   wire ninth_bit_or_upper_select_pin_in, ninth_bit_or_upper_select_pin_out, ninth_bit_or_upper_select_pin_oe;
   wire [7:0] low_data_lines_in, low_data_lines_out, low_data_lines_oe;
   wire [2:0] high_data_lines_in, high_data_lines_out, high_data_lines_oe;
   wire [11:0] d, write_data;
   wire [11:0] bus = {high_data_lines_in, ninth_bit_or_upper_select_pin_in, low_data_lines_in};
   // Each line shows its driving party, else the host's value d (sel on the shared pin in byte mode)
   assign low_data_lines_in = low_data_lines_oe & low_data_lines_out | ~low_data_lines_oe & d[7:0];
   assign high_data_lines_in = high_data_lines_oe & high_data_lines_out | ~high_data_lines_oe & d[11:9];
   assign ninth_bit_or_upper_select_pin_in = ninth_bit_or_upper_select_pin_oe ?
      ninth_bit_or_upper_select_pin_out : (word_byte_sel ? d[8] : sel);
   // Port under test and its host
   adc_word_byte_bus_port uut (
      .clk(clk), .resetn(resetn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .word_byte_sel(word_byte_sel),
      .low_data_lines_in(low_data_lines_in), .low_data_lines_out(low_data_lines_out),
      .low_data_lines_oe(low_data_lines_oe),
      .ninth_bit_or_upper_select_pin_in(ninth_bit_or_upper_select_pin_in),
      .ninth_bit_or_upper_select_pin_out(ninth_bit_or_upper_select_pin_out),
      .ninth_bit_or_upper_select_pin_oe(ninth_bit_or_upper_select_pin_oe),
      .high_data_lines_in(high_data_lines_in), .high_data_lines_out(high_data_lines_out),
      .high_data_lines_oe(high_data_lines_oe),
      .result(result), .result_chan(result_chan),
      .write_data(write_data), .write_strobe(write_strobe), .write_upper_pad_err(write_upper_pad_err)
   );
   host_bus_model host (
      .clk(clk), .bus(bus), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .word_byte_sel(word_byte_sel),
      .sel(sel), .d(d)
   );
   // Clock, strobe count and watchdog
   initial forever #10 clk = ~clk;
   always @(posedge clk) if (write_strobe === 1'b1) strobes++;
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      end_of_test;
   end
   task end_of_test;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Word accesses, then byte accesses for every channel tag
   initial begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      result = 12'hA5C;
      host.acc(1'b0, 1'b0, 12'h000, q);
      `CHK(q, 12'hA5C)
      `CHK(low_data_lines_oe, 8'h00)
      host.acc(1'b1, 1'b0, 12'h3C9, q);
      `CHK(write_data, 12'h3C9)
      `CHK(strobes, 1)
      $display("word tests done");
      host.set_mode(1'b0);
      repeat (5) @(negedge clk);
      for (int c = 0; c < 8; c++) begin
         result = 12'h93C ^ {c[3:0], c[7:0]};
         result_chan = c[2:0];
         host.acc(1'b0, 1'b0, 12'h000, q);
         `CHK(q[7:0], result[7:0])
         host.acc(1'b0, 1'b1, 12'h000, q);
         `CHK(q[7:0], {1'b0, result_chan, result[11:8]})
         `CHK(q[8], 1'b1)
      end
      host.acc(1'b1, 1'b0, 12'h096, q);
      `CHK(strobes, 1)
      host.acc(1'b1, 1'b1, 12'h007, q);
      `CHK(write_data, 12'h796)
      `CHK(write_upper_pad_err, 1'b0)
      host.acc(1'b1, 1'b1, 12'h0F5, q);
      `CHK(write_upper_pad_err, 1'b1)
      `CHK(strobes, 3)
      $display("byte tests done");
      end_of_test;
   end
endmodule
`default_nettype wire

//--- tb/host_bus_model.sv
// Host bus master model: strobes, select and host side of the lines.
// Assumes the bench resolves every line from the port's enables.
`default_nettype none
module host_bus_model (
   // Clock and resolved bus
   input wire logic clk,
   input wire logic [11:0] bus,
   // Strobes and mode
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic word_byte_sel,
   // Upper-byte select and host data
   output logic sel,
   output logic [11:0] d
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cs_n, rd_n, wr_n, word_byte_sel, sel, d} = {5'h1F, 12'h000};
   // Word or byte mode, changed only between accesses
   task set_mode(input logic w);
      word_byte_sel = w;
   endtask
   // One access: strobe low five cycles, answer taken, then an idle gap
   task acc(input logic w, input logic s, input logic [11:0] v, output logic [11:0] q);
      @(negedge clk);
      sel = s;
      d = w ? v : ~d; // Written value, else the inverse of the last
      {cs_n, rd_n, wr_n} = {1'b0, w, !w};
      repeat (5) @(negedge clk);
      q = bus;
      {rd_n, wr_n} = 2'h3;
      @(negedge clk);
      {cs_n, d} = {1'b1, ~d};
      repeat (5) @(negedge clk);
   endtask
endmodule
`default_nettype wire
